// ===== core/cct_pkg.sv
// Summary of operation
// - Counter runs normally and stops whenever timer_on is zero.
// - Each channel pin is capture input or compare output per its mode.
// - Register address is module base plus the register's fixed offset.
// - Mode bit 0 selects input capture, 1 selects output compare.
// - Writes to absent channel bits are ignored; such bits read zero.
// - Only implemented channel bits work; compare registers exist per channel.
// - Force-compare register always reads back zero.
// - Writing one to force_compare performs the channel's compare action now.
// - A forced compare never sets the channel flag.
// - Forced and real compare together: forced wins, no flag set.
// - The free_counter is a 16-bit up counter.
// - Counter writes are ignored in normal mode, accepted in special mode.
// - First count after a counter write may be short, never longer than a full prescaler period.
// - In freeze mode counter stops if halt_in_freeze is one.
// - In wait mode timer stops if halt_in_wait is one.
// - Quick clear: capture read, compare write, counter access clear flags.
// - overflow_toggle flips compare pin on overflow, beating forced compare.
package cct_pkg;
    localparam logic [5:0] CCT_OFS_MODE    = 6'h00;
    localparam logic [5:0] CCT_OFS_FORCE   = 6'h01;
    localparam logic [5:0] CCT_OFS_CNT_HI  = 6'h04;
    localparam logic [5:0] CCT_OFS_CNT_LO  = 6'h05;
    localparam logic [5:0] CCT_OFS_SCR1    = 6'h06;
    localparam logic [5:0] CCT_OFS_TOGGLE  = 6'h07;
    localparam logic [5:0] CCT_OFS_OCTL_HI = 6'h08;
    localparam logic [5:0] CCT_OFS_OCTL_LO = 6'h09;
    localparam logic [5:0] CCT_OFS_EDGE_HI = 6'h0A;
    localparam logic [5:0] CCT_OFS_EDGE_LO = 6'h0B;
    localparam logic [5:0] CCT_OFS_IRQ_EN  = 6'h0C;
    localparam logic [5:0] CCT_OFS_SCR2    = 6'h0D;
    localparam logic [5:0] CCT_OFS_FLAG    = 6'h0E;
    localparam logic [5:0] CCT_OFS_OVF     = 6'h0F;
    localparam logic [5:0] CCT_OFS_CMP0    = 6'h10;
    localparam logic [5:0] CCT_OFS_CMP_END = 6'h1F;
    localparam logic [5:0] CCT_OFS_PIN_DIS = 6'h2C;
    localparam logic [5:0] CCT_OFS_PPRESC  = 6'h2E;
    // Field positions in system_control_one
    localparam int CCT_BIT_TIMER_ON   = 7;
    localparam int CCT_BIT_HALT_WAIT  = 6;
    localparam int CCT_BIT_HALT_FRZ   = 5;
    localparam int CCT_BIT_QUICK_CLR  = 4;
    localparam int CCT_BIT_PREC_SEL   = 3;
    // Field positions in system_control_two and overflow flag register
    localparam int CCT_BIT_OVF_IRQ_EN = 7;
    localparam int CCT_BIT_OVF_FLAG   = 7;
    localparam logic [7:0]  CCT_RST_BYTE = 8'h00;
    localparam logic [15:0] CCT_RST_WORD = 16'h0000;
    localparam logic [15:0] CCT_CNT_MAX  = 16'hFFFF;
    localparam logic [31:0] CCT_RD_ZERO  = 32'h0000_0000;
    localparam logic [31:0] CCT_RD_UNMAP = 32'h0000_0000;
endpackage

// ===== core/cct_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module cct_prescaler
    import cct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       sync_clr,
    input  wire logic       prec_sel,
    input  wire logic [2:0] legacy_sel,
    input  wire logic [7:0] prec_div,
    output logic            tick
);
    logic [7:0] div_cnt;
    logic [7:0] limit;

    // Terminal count: 2^sel-1 legacy, divide by value+1 in precision mode
    always_comb begin
        if (prec_sel) begin
            limit = prec_div;
        end else begin
            limit = 8'((9'h001 << legacy_sel) - 9'h001);
        end
    end

    // Divider; restarts on request but a counter write does not reset it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= CCT_RST_BYTE;
        end else if (sync_clr) begin
            div_cnt <= CCT_RST_BYTE;
        end else if (run) begin
            if (div_cnt >= limit) begin
                div_cnt <= CCT_RST_BYTE;
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    assign tick = run && (div_cnt >= limit);
endmodule
`default_nettype wire

// ===== core/cct_timer.sv
`timescale 1ns/100ps
`default_nettype none
module cct_timer
    import cct_pkg::*;
#(
    parameter int NCH = 4
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic        freeze_mode,
    input  wire logic        wait_mode,
    input  wire logic        special_mode,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  channel_pin_in,
    output logic [3:0]       channel_pin_out,
    output logic [3:0]       channel_pin_oe,
    output logic             channel_irq,
    output logic             overflow_irq
);
    localparam logic [3:0] CH_MASK = 4'((5'h01 << NCH) - 5'h01);

    // Register state
    logic [3:0]  channel_mode_select;
    logic [7:0]  scr1;
    logic [3:0]  overflow_toggle;
    logic [7:0]  out_ctl;
    logic [7:0]  edge_select;
    logic [3:0]  channel_irq_enable;
    logic        overflow_irq_enable;
    logic [2:0]  prescale_select;

    // Flags, pin disconnect and precision prescale state
    logic [3:0]  channel_flag;
    logic        overflow_flag;
    logic [3:0]  compare_pin_disconnect;
    logic [7:0]  precision_prescale;
    logic        prec_locked;

    // Counter and compare state
    logic [15:0] free_counter;
    logic [15:0] channel_compare_value [4];
    logic [3:0]  pin_state;
    logic        ack;

    // Synchronised pins and edge history
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  pin_prev;

    logic        wr_req;
    logic        rd_req;
    logic        wr_lo;
    logic        run;
    logic        tick;
    logic        wrap;
    logic        cnt_wr;
    logic        cnt_acc;

    logic [3:0]  force_hit;
    logic [3:0]  match;
    logic [3:0]  cap_edge;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    logic [3:0]  pin_act;
    logic [3:0]  ch_acc;
    logic [7:0]  wbyte;

    // One-cycle Avalon answer; waitrequest low on the second cycle
    assign wr_req = avs_write && !avs_waitrequest;
    assign rd_req = avs_read && !avs_waitrequest;
    assign wr_lo = wr_req && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else if (clk_en) begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    // Counter runs when enabled and not halted by wait or freeze
    assign run = scr1[CCT_BIT_TIMER_ON]
        && !(freeze_mode && scr1[CCT_BIT_HALT_FRZ])
        && !(wait_mode && scr1[CCT_BIT_HALT_WAIT])
        && clk_en;

    // Counter write reaches the word, unaligned to the prescaler
    assign cnt_wr = wr_req && special_mode
        && (avs_address == CCT_OFS_CNT_HI);
    assign cnt_acc = (wr_req || rd_req)
        && ((avs_address == CCT_OFS_CNT_HI)
            || (avs_address == CCT_OFS_CNT_LO));

    cct_prescaler u_presc (
        .clk        (clk),
        .rstn       (rstn),
        .run        (run),
        .sync_clr   (1'b0),
        .prec_sel   (scr1[CCT_BIT_PREC_SEL]),
        .legacy_sel (prescale_select),
        .prec_div   (precision_prescale),
        .tick       (tick)
    );

    assign wrap = tick && (free_counter == CCT_CNT_MAX);

    // 16-bit up counter; word write at the high offset, prescaler not reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            free_counter <= CCT_RST_WORD;
        end else if (clk_en) begin
            if (cnt_wr) begin
                free_counter <= avs_writedata[15:0];
            end else if (tick) begin
                free_counter <= free_counter + 16'h0001;
            end
        end
    end

    // Pin synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1   <= 4'h0;
            pin_s2   <= 4'h0;
            pin_prev <= 4'h0;
        end else if (clk_en) begin
            pin_s1   <= channel_pin_in;
            pin_s2   <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // Per-channel events
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ch
            // Local views
            logic rise;
            logic fall;
            logic [1:0] es;
            logic [1:0] oc;

            // Pin edges
            assign rise = pin_s2[g] && !pin_prev[g];
            assign fall = !pin_s2[g] && pin_prev[g];

            // Control fields
            assign es = edge_select[2*g+1:2*g];
            assign oc = out_ctl[2*g+1:2*g];

            // Force strobe
            assign force_hit[g] = wr_req && CH_MASK[g]
                && (avs_address == CCT_OFS_FORCE) && wbyte[g]
                && channel_mode_select[g];

            // Compare on tick
            assign match[g] = CH_MASK[g] && channel_mode_select[g]
                && tick && (free_counter == channel_compare_value[g]);

            // Capture edge
            assign cap_edge[g] = CH_MASK[g] && !channel_mode_select[g]
                && ((es[0] && rise) || (es[1] && fall));

            // Forced action suppresses flag, even with a real match
            assign flag_set[g] = (match[g] && !force_hit[g])
                || cap_edge[g];
            assign pin_act[g] = match[g] || force_hit[g];

            // Word window
            assign ch_acc[g] = (avs_address == CCT_OFS_CMP0 + 6'(2*g))
                || (avs_address == CCT_OFS_CMP0 + 6'(2*g+1));

            // Quick flag clear
            assign flag_clr[g] = scr1[CCT_BIT_QUICK_CLR] && ch_acc[g]
                && ((rd_req && !channel_mode_select[g])
                    || (wr_req && channel_mode_select[g]));

            // Compare/capture register; only implemented channels
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    channel_compare_value[g] <= CCT_RST_WORD;
                end else if (clk_en && CH_MASK[g]) begin
                    if (cap_edge[g]) begin
                        channel_compare_value[g] <= free_counter;
                    end else if (wr_req && ch_acc[g]) begin
                        channel_compare_value[g] <= avs_writedata[15:0];
                    end
                end
            end

            // Pin level: overflow toggle beats compare and force
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pin_state[g] <= 1'b0;
                end else if (clk_en) begin
                    if (wrap && overflow_toggle[g]
                        && channel_mode_select[g]) begin
                        pin_state[g] <= !pin_state[g];
                    end else if (pin_act[g]) begin
                        case (oc)
                            2'b01: pin_state[g] <= !pin_state[g];
                            2'b10: pin_state[g] <= 1'b0;
                            2'b11: pin_state[g] <= 1'b1;
                            default: pin_state[g] <= pin_state[g];
                        endcase
                    end
                end
            end

            // Pin drives only in compare mode with action and not disconnected
            assign channel_pin_oe[g] = CH_MASK[g]
                && channel_mode_select[g] && (oc != 2'b00)
                && !compare_pin_disconnect[g];
            assign channel_pin_out[g] = pin_state[g] && channel_pin_oe[g];
        end
    endgenerate

    // Channel flags: write one clears, set beats clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_flag <= 4'h0;
        end else if (clk_en) begin
            channel_flag <= (flag_set | (channel_flag & ~flag_clr
                & ~((wr_lo && (avs_address == CCT_OFS_FLAG))
                    ? wbyte[3:0] : 4'h0))) & CH_MASK;
        end
    end

    // Overflow flag: set on wrap, cleared by write one or quick clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overflow_flag <= 1'b0;
        end else if (clk_en) begin
            if (wrap) begin
                overflow_flag <= 1'b1;
            end else if (scr1[CCT_BIT_QUICK_CLR] && cnt_acc) begin
                overflow_flag <= 1'b0;
            end else if (wr_lo && (avs_address == CCT_OFS_OVF)
                && wbyte[CCT_BIT_OVF_FLAG]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // Control registers; absent-channel bits masked on write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channel_mode_select    <= 4'h0;
            scr1                   <= CCT_RST_BYTE;
            overflow_toggle        <= 4'h0;
            out_ctl                <= CCT_RST_BYTE;
            edge_select            <= CCT_RST_BYTE;
            channel_irq_enable     <= 4'h0;
            overflow_irq_enable    <= 1'b0;
            prescale_select        <= 3'h0;
            compare_pin_disconnect <= 4'h0;
            precision_prescale     <= CCT_RST_BYTE;
            prec_locked            <= 1'b0;
        end else if (clk_en && wr_lo) begin
            case (avs_address)
                CCT_OFS_MODE:
                    channel_mode_select <= wbyte[3:0] & CH_MASK;
                CCT_OFS_SCR1: begin
                    scr1[7:4] <= wbyte[7:4];
                    if (!prec_locked) begin
                        scr1[CCT_BIT_PREC_SEL] <= wbyte[CCT_BIT_PREC_SEL];
                        prec_locked <= 1'b1;
                    end
                end
                CCT_OFS_TOGGLE:
                    overflow_toggle <= wbyte[3:0] & CH_MASK;
                CCT_OFS_OCTL_LO:
                    out_ctl <= wbyte & {{2{CH_MASK[3]}}, {2{CH_MASK[2]}},
                        {2{CH_MASK[1]}}, {2{CH_MASK[0]}}};
                CCT_OFS_EDGE_LO:
                    edge_select <= wbyte & {{2{CH_MASK[3]}},
                        {2{CH_MASK[2]}}, {2{CH_MASK[1]}}, {2{CH_MASK[0]}}};
                CCT_OFS_IRQ_EN:
                    channel_irq_enable <= wbyte[3:0] & CH_MASK;
                CCT_OFS_SCR2: begin
                    overflow_irq_enable <= wbyte[CCT_BIT_OVF_IRQ_EN];
                    prescale_select <= wbyte[2:0];
                end
                CCT_OFS_PIN_DIS:
                    compare_pin_disconnect <= wbyte[3:0] & CH_MASK;
                CCT_OFS_PPRESC:
                    precision_prescale <= wbyte;
                default: begin
                end
            endcase
        end
    end

    // Read data registered at the answering edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= CCT_RD_ZERO;
        end else if (clk_en && avs_read && !ack) begin
            case (avs_address)
                CCT_OFS_MODE:    avs_readdata <= {28'h0, channel_mode_select};
                CCT_OFS_FORCE:   avs_readdata <= CCT_RD_ZERO;
                CCT_OFS_CNT_HI:  avs_readdata <= {16'h0, free_counter};
                CCT_OFS_CNT_LO:  avs_readdata <= {24'h0, free_counter[7:0]};
                CCT_OFS_SCR1:    avs_readdata <= {24'h0, scr1[7:3], 3'h0};
                CCT_OFS_TOGGLE:  avs_readdata <= {28'h0, overflow_toggle};
                CCT_OFS_OCTL_LO: avs_readdata <= {24'h0, out_ctl};
                CCT_OFS_EDGE_LO: avs_readdata <= {24'h0, edge_select};
                CCT_OFS_IRQ_EN:  avs_readdata <= {28'h0, channel_irq_enable};
                CCT_OFS_SCR2:    avs_readdata <= {24'h0, overflow_irq_enable,
                                     4'h0, prescale_select};
                CCT_OFS_FLAG:    avs_readdata <= {28'h0, channel_flag};
                CCT_OFS_OVF:     avs_readdata <= {24'h0, overflow_flag, 7'h0};
                CCT_OFS_PIN_DIS: avs_readdata <= {28'h0,
                                     compare_pin_disconnect};
                CCT_OFS_PPRESC:  avs_readdata <= {24'h0, precision_prescale};
                default: begin
                    if (avs_address >= CCT_OFS_CMP0
                        && avs_address <= CCT_OFS_CMP_END
                        && !avs_address[3]
                        && CH_MASK[avs_address[2:1]]) begin
                        avs_readdata <= {16'h0,
                            channel_compare_value[avs_address[2:1]]};
                    end else begin
                        avs_readdata <= CCT_RD_UNMAP;
                    end
                end
            endcase
        end
    end

    // Interrupt requests from flags and enables
    assign channel_irq  = |(channel_flag & channel_irq_enable);
    assign overflow_irq = overflow_flag && overflow_irq_enable;
endmodule
`default_nettype wire

// ===== test/cct_timer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module cct_timer_chk
    import cct_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        clk_en,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  channel_pin_out,
    input wire logic [3:0]  channel_pin_oe,
    input wire logic        channel_irq,
    input wire logic        overflow_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic req;
    logic rd_done;
    logic req_q;
    logic wr_done_q;

    // Request and completion views
    assign req = avs_read || avs_write;
    assign rd_done = avs_read && !avs_waitrequest && clk_en;

    // Previous-cycle request and write completion
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_q <= 1'b0;
            wr_done_q <= 1'b0;
        end else begin
            req_q <= req;
            wr_done_q <= avs_write && !avs_waitrequest && clk_en;
        end
    end

    property p_req_wait;
        req && !req_q |-> avs_waitrequest;
    endproperty
    a_req_wait: assert property (p_req_wait)
        else $error("no wait first");
    property p_wait_short;
        req && avs_waitrequest && clk_en |=> !avs_waitrequest;
    endproperty
    a_wait_short: assert property (p_wait_short)
        else $error("wait too long");
    property p_force_zero;
        rd_done && avs_address == CCT_OFS_FORCE
            |-> avs_readdata == CCT_RD_ZERO;
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("force reads");
    property p_mode_rsvd;
        rd_done && avs_address == CCT_OFS_MODE |-> avs_readdata[31:4] == '0;
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd)
        else $error("mode bits");
    property p_flag_rsvd;
        rd_done && avs_address == CCT_OFS_FLAG |-> avs_readdata[31:4] == '0;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd)
        else $error("flag bits");
    property p_ovf_rsvd;
        rd_done && avs_address == CCT_OFS_OVF
            |-> (avs_readdata & 32'hFFFF_FF7F) == '0;
    endproperty
    a_ovf_rsvd: assert property (p_ovf_rsvd)
        else $error("ovf bits");
    property p_unmapped;
        rd_done && avs_address == 6'h2D |-> avs_readdata == CCT_RD_UNMAP;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped");
    property p_oe_cause;
        rstn && $changed(channel_pin_oe) |-> wr_done_q;
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("oe moved");
    property p_hold_off;
        !clk_en |=> $stable(channel_pin_out) && $stable(overflow_irq);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("ran while off");

    // Main scenarios reached
    c_force_rd: cover property (rd_done && avs_address == CCT_OFS_FORCE);
    c_ovf: cover property ($rose(overflow_irq));
    c_irq: cover property ($rose(channel_irq));
endmodule

bind cct_timer cct_timer_chk chk_u (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .channel_irq(channel_irq),
    .overflow_irq(overflow_irq)
);
`default_nettype wire

// ===== test/cct_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module cct_pin_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] src_lvl,
    output logic      [3:0] pin_in
);
    // Pin level: timer drives when enabled, else the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_lvl);
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import cct_pkg::*;
;
    logic        clk, rstn, clk_en, freeze_mode, wait_mode, special_mode;
    logic        avs_read, avs_write, avs_waitrequest, channel_irq, overflow_irq;
    logic [5:0]  avs_address, obs;
    logic [3:0]  avs_byteenable, channel_pin_in, channel_pin_out;
    logic [3:0]  channel_pin_oe, src_lvl;
    logic [31:0] avs_writedata, avs_readdata, rd, a, b, c, exp_m, msk_m;
    logic [31:0] note_q[$];
    logic [31:0] mask_q[$];
    logic [31:0] halt_v[3] = '{32'hA0, 32'hC0, 32'h00};
    int          failures, samples_checked, seed, i;

    cct_timer #(.NCH(4)) dut_u (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .freeze_mode(freeze_mode),
        .wait_mode(wait_mode), .special_mode(special_mode),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
        .channel_pin_oe(channel_pin_oe), .channel_irq(channel_irq),
        .overflow_irq(overflow_irq)
    );
    cct_pin_model pin_u (
        .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
        .src_lvl(src_lvl), .pin_in(channel_pin_in)
    );
    assign obs = {channel_irq, overflow_irq, channel_pin_out};

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic fail(input string msg);
        failures++;
        $display("BAD %0t %s", $time, msg);
    endtask
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) fail(msg);
    endtask
    // One bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] ad,
                       input logic [31:0] wd, input logic [31:0] ex,
                       input logic [31:0] mk);
        int n;
        @(posedge clk);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        if (!wr) begin
            note_q.push_back(ex);
            mask_q.push_back(mk);
        end
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            fail("bus hang");
            tally_and_finish();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, '0, '0);
    endtask
    task automatic rdx(input logic [5:0] ad, input logic [31:0] ex);
        bus(1'b0, ad, '0, ex, '1);
    endtask
    task automatic rdv(input logic [5:0] ad);
        bus(1'b0, ad, '0, '0, '0);
    endtask
    // Wait on one observed output bit, bounded
    task automatic wsig(input int idx, input logic v, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge clk);
            if (obs[idx] === v) break;
        end
        chk(n < lim, "output bit never reached level");
    endtask

    // Read checker: pops oldest note on each completed read, compares only when its mask is nonzero
    always @(negedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && clk_en) begin
            if (note_q.size() == 0) begin
                fail("read without note");
            end else begin
                exp_m = note_q.pop_front();
                msk_m = mask_q.pop_front();
                if (msk_m !== '0) begin
                    samples_checked++;
                    if ((avs_readdata & msk_m) !== exp_m)
                        fail("read data");
                end
            end
        end
    end

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk);
        fail("run timeout");
        tally_and_finish();
    end

    // Main sequence
    initial begin
        seed = 64737;
        failures = 0;
        samples_checked = 0;
        rstn = 1'b0;
        clk_en = 1'b1;
        freeze_mode = 1'b0;
        wait_mode = 1'b0;
        special_mode = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hF;
        avs_writedata = '0;
        src_lvl = 4'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdx(CCT_OFS_MODE, 32'h0);
        wr(CCT_OFS_MODE, 32'hFF);
        rdx(CCT_OFS_MODE, 32'h0F);
        wr(CCT_OFS_FORCE, 32'hFF);
        rdx(CCT_OFS_FORCE, 32'h0);
        wr(6'h2D, 32'hFF);
        rdx(6'h2D, 32'h0);
        rdx(CCT_OFS_OCTL_HI, 32'h0);
        $display("test regs done");
        wr(CCT_OFS_MODE, 32'h03);
        wr(CCT_OFS_OCTL_LO, 32'h0D);
        wr(CCT_OFS_EDGE_LO, 32'h10);
        wr(CCT_OFS_IRQ_EN, 32'h0F);
        wr(CCT_OFS_SCR2, 32'h80);
        wr(CCT_OFS_CMP0 + 6'h2, 32'h8000);
        rdx(CCT_OFS_CNT_HI, 32'h0);
        wr(CCT_OFS_CNT_HI, 32'h1234);
        rdx(CCT_OFS_CNT_HI, 32'h0);
        special_mode <= 1'b1;
        wr(CCT_OFS_CNT_HI, 32'hFFF0);
        special_mode <= 1'b0;
        rdx(CCT_OFS_CNT_HI, 32'hFFF0);
        rdx(CCT_OFS_CNT_LO, 32'hF0);
        $display("test counter write done");
        wr(CCT_OFS_FORCE, 32'h03);
        wsig(0, 1'b1, 4);
        wsig(1, 1'b1, 4);
        chk(channel_pin_oe === 4'h3, "pin drive");
        rdx(CCT_OFS_FLAG, 32'h0);
        chk(channel_irq === 1'b0, "irq after force");
        $display("test force done");
        wr(CCT_OFS_CMP0, 32'hFFF8);
        wr(CCT_OFS_SCR1, 32'h80);
        wsig(0, 1'b0, 40);
        wsig(4, 1'b1, 40);
        rdx(CCT_OFS_FLAG, 32'h01);
        rdx(CCT_OFS_OVF, 32'h80);
        chk(channel_irq === 1'b1, "channel irq");
        wr(CCT_OFS_FLAG, 32'h0F);
        wr(CCT_OFS_OVF, 32'h80);
        rdx(CCT_OFS_FLAG, 32'h0);
        $display("test compare done");
        for (i = 0; i < 3; i++) begin
            freeze_mode <= (i == 0);
            wait_mode <= (i == 1);
            wr(CCT_OFS_SCR1, halt_v[i]);
            rdv(CCT_OFS_CNT_HI);
            a = rd;
            repeat (8) @(posedge clk);
            rdx(CCT_OFS_CNT_HI, a);
            freeze_mode <= 1'b0;
            wait_mode <= 1'b0;
            wr(CCT_OFS_SCR1, 32'h80);
            rdv(CCT_OFS_CNT_HI);
            chk(rd !== a, "counter resumes");
        end
        $display("test halt done");
        rdv(CCT_OFS_CNT_HI);
        a = rd;
        src_lvl <= 4'h4;
        repeat (8) @(posedge clk);
        rdv(CCT_OFS_CNT_HI);
        b = rd;
        rdv(CCT_OFS_CMP0 + 6'h4);
        c = rd;
        chk(c > a && c < b, "capture time");
        rdx(CCT_OFS_FLAG, 32'h04);
        $display("test capture done");
        for (i = 0; i < 4; i++) begin
            a = $random(seed) & 32'hFFFF;
            src_lvl <= {a[0], 3'h4};
            wr(CCT_OFS_CMP0 + 6'h6, a);
            rdx(CCT_OFS_CMP0 + 6'h6, a);
        end
        rdx(6'h18, 32'h0);
        clk_en <= 1'b0;
        repeat (6) @(posedge clk);
        clk_en <= 1'b1;
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rdx(CCT_OFS_MODE, 32'h0);
        chk(channel_pin_out === 4'h0, "pins after reset");
        chk(note_q.size() == 0, "notes left");
        $display("test random and reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
